// ==== csf_consts.vh ====
`ifndef CSF_CONSTS_VH
`define CSF_CONSTS_VH

`define CSF_ADDR_WORK 8'h05
`define CSF_ADDR_PCL 8'h06
`define CSF_ADDR_LPTR 8'h07
`define CSF_ADDR_LHIGH 8'h08
`define CSF_ADDR_STATUS 8'h0a
`define CSF_ADDR_EVSTAT 8'h30
`define CSF_ADDR_EVMASK 8'h31

`define CSF_BIT_C 0
`define CSF_BIT_AC 1
`define CSF_BIT_Z 2
`define CSF_BIT_OV 3
`define CSF_BIT_PDF 4
`define CSF_BIT_TO 5

`define CSF_EV_DOG 0
`define CSF_EV_TABLE 1
`define CSF_EV_JUMP 2
`define CSF_EV_SLEEP 3
`define CSF_EV_W 4

`define CSF_RST_BYTE 8'h00
`define CSF_RST_EV 4'h0
`define CSF_DUMMY_CYCLES 4'h1

`define CSF_OP_ADD 4'h0
`define CSF_OP_ADC 4'h1
`define CSF_OP_SUB 4'h2
`define CSF_OP_SBC 4'h3
`define CSF_OP_AND 4'h4
`define CSF_OP_OR 4'h5
`define CSF_OP_XOR 4'h6
`define CSF_OP_CPL 4'h7
`define CSF_OP_INC 4'h8
`define CSF_OP_DEC 4'h9
`define CSF_OP_RRC 4'ha
`define CSF_OP_RLC 4'hb
`define CSF_OP_MOVB 4'hc
`define CSF_OP_MOVA 4'hd
`define CSF_OP_CLR 4'he
`define CSF_OP_NOP 4'hf

`endif

// ==== csf_alu.v ====
`timescale 1ns/1ps
`include "csf_consts.vh"

module csf_alu (
    input wire [7:0] opA,
    input wire [7:0] opB,
    input wire carryIn,
    input wire [3:0] opCode,
    output reg [7:0] result,
    output reg carryOut,
    output reg halfOut,
    output reg wrapOut,
    output wire zeroOut,
    output reg [3:0] updMask
);

    reg [10:0] sum;

    // Returns {carry out, carry into bit 7, carry out of low nibble, sum}.
    function [10:0] addc;
        input [7:0] x;
        input [7:0] y;
        input ci;
        reg [4:0] lo;
        reg [3:0] mid;
        reg [1:0] hi;
        begin
            lo = {1'b0, x[3:0]} + {1'b0, y[3:0]} + {4'h0, ci};
            mid = {1'b0, x[6:4]} + {1'b0, y[6:4]} + {3'h0, lo[4]};
            hi = {1'b0, x[7]} + {1'b0, y[7]} + {1'b0, mid[3]};
            addc = {hi[1], mid[3], lo[4], hi[0], mid[2:0], lo[3:0]};
        end
    endfunction

    assign zeroOut = (result == 8'h00);

    always @* begin
        sum = 11'h000;
        result = opB;
        carryOut = carryIn;
        halfOut = 1'b0;
        wrapOut = 1'b0;
        updMask = 4'h0;
        case (opCode)
            `CSF_OP_ADD, `CSF_OP_ADC, `CSF_OP_SUB, `CSF_OP_SBC: begin
                // Subtraction adds the inverse, so carry means no borrow.
                if (opCode == `CSF_OP_ADD)
                    sum = addc(opA, opB, 1'b0);
                else if (opCode == `CSF_OP_ADC)
                    sum = addc(opA, opB, carryIn);
                else if (opCode == `CSF_OP_SUB)
                    sum = addc(opA, ~opB, 1'b1);
                else
                    sum = addc(opA, ~opB, carryIn);
                result = sum[7:0];
                carryOut = sum[10];
                halfOut = sum[8];
                wrapOut = sum[10] ^ sum[9];
                updMask = 4'hf;
            end
            `CSF_OP_AND: begin
                result = opA & opB;
                updMask = 4'h4;
            end
            `CSF_OP_OR: begin
                result = opA | opB;
                updMask = 4'h4;
            end
            `CSF_OP_XOR: begin
                result = opA ^ opB;
                updMask = 4'h4;
            end
            `CSF_OP_CPL: begin
                result = ~opB;
                updMask = 4'h4;
            end
            `CSF_OP_INC: begin
                sum = addc(opB, 8'h00, 1'b1);
                result = sum[7:0];
                updMask = 4'h4;
            end
            `CSF_OP_DEC: begin
                sum = addc(opB, 8'hff, 1'b0);
                result = sum[7:0];
                updMask = 4'h4;
            end
            `CSF_OP_RRC: begin
                result = {carryIn, opB[7:1]};
                carryOut = opB[0];
                updMask = 4'h1;
            end
            `CSF_OP_RLC: begin
                result = {opB[6:0], carryIn};
                carryOut = opB[7];
                updMask = 4'h1;
            end
            `CSF_OP_MOVB: result = opB;
            `CSF_OP_MOVA: result = opA;
            `CSF_OP_CLR: result = 8'h00;
            default: result = opB;
        endcase
    end

endmodule // csf_alu

// ==== csf_core_flags.v ====
`timescale 1ns/1ps
`include "csf_consts.vh"

module csf_core_flags #(
    parameter PC_W = 11,
    parameter TW = 16
) (
    input wire mclk,
    input wire rst_n,
    input wire ce,
    input wire [7:0] regAddr,
    input wire [7:0] regWdata,
    input wire regWr,
    input wire regRd,
    output reg [7:0] regRdata,
    input wire opValid,
    input wire [3:0] opCode,
    input wire [7:0] opOperand,
    input wire opToWork,
    input wire [7:0] opDestAddr,
    input wire fetchStep,
    input wire sleepInstr,
    input wire dogRefreshInstr,
    input wire dogExpire,
    input wire tableRead,
    input wire [TW-1:0] tableWord,
    input wire [7:0] tableDest,
    output reg [7:0] workReg,
    output reg [PC_W-1:0] progCounter,
    output reg dummyCycle,
    output reg [7:0] lookupPointer,
    output reg [7:0] lookupHighByte,
    output reg [7:0] statusFlags,
    output reg memWrEn,
    output reg [7:0] memWrAddr,
    output reg [7:0] memWrData,
    output reg irq
);

    localparam [3:0] DUMMY_N = `CSF_DUMMY_CYCLES;

    reg [7:0] work_ff;
    reg [PC_W-1:0] pc_ff;
    reg dummy_ff;
    reg [3:0] dummyCnt_ff;
    reg [7:0] lptr_ff;
    reg [7:0] lhigh_ff;
    reg [3:0] arith_ff;
    reg sleepFlag_ff;
    reg dogFlag_ff;
    reg [3:0] evStat_ff;
    reg [3:0] evMask_ff;

    reg [7:0] nxt_work;
    reg [PC_W-1:0] nxt_pc;
    reg nxt_dummy;
    reg [3:0] nxt_dummyCnt;
    reg [7:0] nxt_lptr;
    reg [7:0] nxt_lhigh;
    reg [3:0] nxt_arith;
    reg nxt_sleepFlag;
    reg nxt_dogFlag;
    reg [3:0] nxt_evStat;
    reg [3:0] nxt_evMask;
    reg nxt_memWrEn;
    reg [7:0] nxt_memWrAddr;
    reg [7:0] nxt_memWrData;
    reg [7:0] nxt_rdata;

    reg [7:0] dstData;
    reg [7:0] dstAddr;
    reg dstToWork;
    reg dstValid;
    reg [3:0] evSet;

    wire [7:0] aluRes;
    wire aluC;
    wire aluAc;
    wire aluOv;
    wire aluZ;
    wire [3:0] aluMask;

    // Bits 7 and 6 read as zero; the two system flags sit above the four.
    function [7:0] statusByte;
        input dogF;
        input sleepF;
        input [3:0] ar;
        begin
            statusByte = {2'b00, dogF, sleepF, ar};
        end
    endfunction

    csf_alu u_alu (
        .opA(work_ff),
        .opB(opOperand),
        .carryIn(arith_ff[`CSF_BIT_C]),
        .opCode(opCode),
        .result(aluRes),
        .carryOut(aluC),
        .halfOut(aluAc),
        .wrapOut(aluOv),
        .zeroOut(aluZ),
        .updMask(aluMask)
    );

    always @* begin
        nxt_work = work_ff;
        nxt_pc = pc_ff;
        nxt_dummy = 1'b0;
        // Counting down lets a deeper fetch pipe stretch the stall by a
        // constant alone, without touching the jump logic.
        nxt_dummyCnt = dummyCnt_ff;
        if (dummyCnt_ff != 4'h0)
            nxt_dummyCnt = dummyCnt_ff - 4'h1;
        nxt_lptr = lptr_ff;
        nxt_lhigh = lhigh_ff;
        nxt_arith = arith_ff;
        nxt_sleepFlag = sleepFlag_ff;
        nxt_dogFlag = dogFlag_ff;
        nxt_evMask = evMask_ff;
        nxt_memWrEn = 1'b0;
        nxt_memWrAddr = 8'h00;
        nxt_memWrData = 8'h00;
        nxt_rdata = 8'h00;
        evSet = 4'h0;
        dstData = 8'h00;
        dstAddr = 8'h00;
        dstToWork = 1'b0;
        dstValid = 1'b0;

        // An instruction result takes the destination; a port write in the
        // same cycle is dropped, since the decoder owns the data path.
        if (opValid && opCode != `CSF_OP_NOP) begin
            dstValid = 1'b1;
            dstData = aluRes;
            dstAddr = opDestAddr;
            dstToWork = opToWork;
            if (opCode == `CSF_OP_MOVB)
                dstToWork = 1'b1;
            if (opCode == `CSF_OP_MOVA)
                dstToWork = 1'b0;
        end else if (tableRead) begin
            dstValid = 1'b1;
            dstData = tableWord[7:0];
            dstAddr = tableDest;
            nxt_lhigh = tableWord[TW-1:TW-8];
            evSet[`CSF_EV_TABLE] = 1'b1;
        end else if (regWr && !opValid) begin
            dstValid = 1'b1;
            dstData = regWdata;
            dstAddr = regAddr;
        end

        // Flags from the operation; untouched flags hold their value.
        if (opValid) begin
            if (aluMask[`CSF_BIT_C])
                nxt_arith[`CSF_BIT_C] = aluC;
            if (aluMask[`CSF_BIT_AC])
                nxt_arith[`CSF_BIT_AC] = aluAc;
            if (aluMask[`CSF_BIT_Z])
                nxt_arith[`CSF_BIT_Z] = aluZ;
            if (aluMask[`CSF_BIT_OV])
                nxt_arith[`CSF_BIT_OV] = aluOv;
        end

        if (fetchStep && !dummy_ff)
            nxt_pc = pc_ff + {{(PC_W-1){1'b0}}, 1'b1};

        if (dstValid && dstToWork) begin
            nxt_work = dstData;
        end else if (dstValid) begin
            case (dstAddr)
                `CSF_ADDR_WORK: nxt_work = dstData;
                `CSF_ADDR_PCL: begin
                    nxt_pc = {pc_ff[PC_W-1:8], dstData};
                    nxt_dummyCnt = DUMMY_N;
                    evSet[`CSF_EV_JUMP] = 1'b1;
                end
                `CSF_ADDR_LPTR: nxt_lptr = dstData;
                `CSF_ADDR_LHIGH: nxt_lhigh = dstData;
                `CSF_ADDR_STATUS: nxt_arith = dstData[3:0];
                `CSF_ADDR_EVMASK: nxt_evMask = dstData[3:0];
                `CSF_ADDR_EVSTAT: ;
                default: begin
                    nxt_memWrEn = 1'b1;
                    nxt_memWrAddr = dstAddr;
                    nxt_memWrData = dstData;
                end
            endcase
        end

        nxt_dummy = (nxt_dummyCnt != 4'h0);

        // Refresh and sleep are exclusive instructions; refresh is checked
        // first only so that the mux has a fixed order.
        if (dogRefreshInstr) begin
            nxt_sleepFlag = 1'b0;
            nxt_dogFlag = 1'b0;
        end else if (sleepInstr) begin
            nxt_sleepFlag = 1'b1;
            nxt_dogFlag = 1'b0;
            evSet[`CSF_EV_SLEEP] = 1'b1;
        end
        // An expiry in the same cycle as a clearing instruction still wins.
        if (dogExpire) begin
            nxt_dogFlag = 1'b1;
            evSet[`CSF_EV_DOG] = 1'b1;
        end

        // Write-one-to-clear, with a new event taking priority over a clear.
        nxt_evStat = evStat_ff;
        if (regWr && !opValid && !tableRead && regAddr == `CSF_ADDR_EVSTAT)
            nxt_evStat = evStat_ff & ~regWdata[3:0];
        nxt_evStat = nxt_evStat | evSet;

        if (regRd) begin
            case (regAddr)
                `CSF_ADDR_WORK: nxt_rdata = work_ff;
                `CSF_ADDR_PCL: nxt_rdata = pc_ff[7:0];
                `CSF_ADDR_LPTR: nxt_rdata = lptr_ff;
                `CSF_ADDR_LHIGH: nxt_rdata = lhigh_ff;
                `CSF_ADDR_STATUS:
                    nxt_rdata = statusByte(dogFlag_ff, sleepFlag_ff,
                        arith_ff);
                `CSF_ADDR_EVSTAT: nxt_rdata = {4'h0, evStat_ff};
                `CSF_ADDR_EVMASK: nxt_rdata = {4'h0, evMask_ff};
                default: nxt_rdata = 8'h00;
            endcase
        end
    end

    // The status byte has no path to any stack; callers save it themselves.
    always @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            work_ff <= `CSF_RST_BYTE;
            pc_ff <= {PC_W{1'b0}};
            dummy_ff <= 1'b0;
            dummyCnt_ff <= 4'h0;
            lptr_ff <= `CSF_RST_BYTE;
            lhigh_ff <= `CSF_RST_BYTE;
            arith_ff <= 4'h0;
            sleepFlag_ff <= 1'b0;
            dogFlag_ff <= 1'b0;
            evStat_ff <= `CSF_RST_EV;
            evMask_ff <= `CSF_RST_EV;
        end else if (ce) begin
            work_ff <= nxt_work;
            pc_ff <= nxt_pc;
            dummy_ff <= nxt_dummy;
            dummyCnt_ff <= nxt_dummyCnt;
            lptr_ff <= nxt_lptr;
            lhigh_ff <= nxt_lhigh;
            arith_ff <= nxt_arith;
            sleepFlag_ff <= nxt_sleepFlag;
            dogFlag_ff <= nxt_dogFlag;
            evStat_ff <= nxt_evStat;
            evMask_ff <= nxt_evMask;
        end
    end

    // Outputs are registered copies so every port comes from a flip-flop.
    always @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            workReg <= `CSF_RST_BYTE;
            progCounter <= {PC_W{1'b0}};
            dummyCycle <= 1'b0;
            lookupPointer <= `CSF_RST_BYTE;
            lookupHighByte <= `CSF_RST_BYTE;
            statusFlags <= `CSF_RST_BYTE;
            memWrEn <= 1'b0;
            memWrAddr <= 8'h00;
            memWrData <= 8'h00;
            regRdata <= 8'h00;
            irq <= 1'b0;
        end else if (ce) begin
            workReg <= nxt_work;
            progCounter <= nxt_pc;
            dummyCycle <= nxt_dummy;
            lookupPointer <= nxt_lptr;
            lookupHighByte <= nxt_lhigh;
            statusFlags <= statusByte(nxt_dogFlag, nxt_sleepFlag, nxt_arith);
            memWrEn <= nxt_memWrEn;
            memWrAddr <= nxt_memWrAddr;
            memWrData <= nxt_memWrData;
            regRdata <= nxt_rdata;
            irq <= |(nxt_evStat & nxt_evMask);
        end
    end

endmodule // csf_core_flags

// ==== csf_chk_asserts.sv ====
`timescale 1ns/1ps
`include "csf_consts.vh"

module csf_chk #(
    parameter PC_W = 11,
    parameter TW = 16
) (
    input wire mclk,
    input wire rst_n,
    input wire ce,
    input wire [7:0] regAddr,
    input wire [7:0] regWdata,
    input wire regWr,
    input wire [3:0] opCode,
    input wire opValid,
    input wire [7:0] opOperand,
    input wire opToWork,
    input wire [7:0] opDestAddr,
    input wire fetchStep,
    input wire sleepInstr,
    input wire dogRefreshInstr,
    input wire dogExpire,
    input wire tableRead,
    input wire [TW-1:0] tableWord,
    input wire [7:0] tableDest,
    input wire [7:0] workReg,
    input wire [PC_W-1:0] progCounter,
    input wire dummyCycle,
    input wire [7:0] lookupHighByte,
    input wire [7:0] statusFlags,
    input wire memWrEn,
    input wire [7:0] memWrAddr,
    input wire [7:0] memWrData
);
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!rst_n);
    wire sysIdle = !sleepInstr && !dogRefreshInstr && !dogExpire;
    wire stWr = regWr && regAddr == `CSF_ADDR_STATUS && !opValid && !tableRead;
    wire isMova = ce && opValid && opCode == `CSF_OP_MOVA;
    wire jmp = isMova && opDestAddr == `CSF_ADDR_PCL && !fetchStep;
    // The upper page bits must survive an in-page jump.
    sequence s_pcLoad;
        progCounter[7:0] == $past(workReg) &&
        progCounter[PC_W-1:8] == $past(progCounter[PC_W-1:8]);
    endsequence
    property p_jump;
        jmp |=> s_pcLoad ##[0:1] dummyCycle;
    endproperty
    a_jump: assert property (p_jump) else $error("jump wrong");
    property p_stWr;
        ce && stWr && sysIdle |=> statusFlags[3:0] == $past(regWdata[3:0])
            && $stable(statusFlags[5:4]);
    endproperty
    a_stWr: assert property (p_stWr) else $error("status write");
    property p_hi;
        statusFlags[7:6] == 2'b00;
    endproperty
    a_hi: assert property (p_hi) else $error("status top bits");
    property p_sleep;
        ce && sleepInstr && !dogExpire && !dogRefreshInstr
            |=> statusFlags[5:4] == 2'b01;
    endproperty
    a_sleep: assert property (p_sleep) else $error("sleep");
    property p_refr;
        ce && dogRefreshInstr && !sleepInstr && !dogExpire
            |=> statusFlags[5:4] == 2'b00;
    endproperty
    a_refr: assert property (p_refr) else $error("refresh");
    property p_exp;
        ce && dogExpire |=> statusFlags[5];
    endproperty
    a_exp: assert property (p_exp) else $error("expiry");
    property p_pdf;
        ce && !sleepInstr && !dogRefreshInstr |=> $stable(statusFlags[4]);
    endproperty
    a_pdf: assert property (p_pdf) else $error("sleep flag moved");
    property p_hold;
        ce && !opValid && !stWr && !(tableRead &&
            tableDest == `CSF_ADDR_STATUS) |=> $stable(statusFlags[3:0]);
    endproperty
    a_hold: assert property (p_hold) else $error("flags moved");
    property p_tbl;
        ce && tableRead && !opValid && tableDest != `CSF_ADDR_LHIGH
            |=> lookupHighByte == $past(tableWord[TW-1:TW-8]);
    endproperty
    a_tbl: assert property (p_tbl) else $error("table high");
    property p_mem;
        isMova && opDestAddr == 8'h40 |=> memWrEn && memWrAddr == 8'h40
            && memWrData == $past(workReg);
    endproperty
    a_mem: assert property (p_mem) else $error("memory write");
    property p_work;
        ce && opValid && opCode == `CSF_OP_MOVB |=> workReg == $past(opOperand);
    endproperty
    a_work: assert property (p_work) else $error("work load");
endmodule // csf_chk

bind csf_core_flags csf_chk #(.PC_W(PC_W), .TW(TW)) u_chk (.*);

// ==== tb_top.sv ====
`timescale 1ns/1ps
`include "csf_consts.vh"

module tb_top;
    reg mclk, rst_n, ce, regWr, regRd, opValid, opToWork, fetchStep;
    reg sleepInstr, dogRefreshInstr, dogExpire, tableRead, d0;
    reg [7:0] regAddr, regWdata, opOperand, opDestAddr, tableDest;
    reg [3:0] opCode;
    reg [15:0] tableWord;
    wire [7:0] regRdata, workReg, lookupPointer, lookupHighByte;
    wire [7:0] statusFlags, memWrAddr, memWrData;
    wire [10:0] progCounter;
    wire dummyCycle, memWrEn, irq;
    integer n_errors, n_compared, cyc;

    csf_core_flags #(.PC_W(11), .TW(16)) uut (
        .mclk, .rst_n, .ce, .regAddr, .regWdata, .regWr, .regRd, .regRdata,
        .opValid, .opCode, .opOperand, .opToWork, .opDestAddr, .fetchStep,
        .sleepInstr, .dogRefreshInstr, .dogExpire, .tableRead, .tableWord,
        .tableDest, .workReg, .progCounter, .dummyCycle, .lookupPointer,
        .lookupHighByte, .statusFlags, .memWrEn, .memWrAddr, .memWrData, .irq
    );

    always #10 mclk = ~mclk;

    task chk(input [23:0] s, input [23:0] e);
        n_compared = n_compared + 1;
        if (s !== e) begin
            n_errors = n_errors + 1;
            $display("[ERR] t=%0t seen=%h exp=%h", $time, s, e);
        end
    endtask
    task wr(input [7:0] a, input [7:0] d);
        @(posedge mclk) regWr <= 1'b1;
        regAddr <= a;
        regWdata <= d;
        @(posedge mclk) regWr <= 1'b0;
        #1;
    endtask
    // Read data stand only in the cycle after the strobe, so look there.
    task rd(input [7:0] a, input [7:0] e);
        @(posedge mclk) regRd <= 1'b1;
        regAddr <= a;
        @(posedge mclk) regRd <= 1'b0;
        #1;
        chk(regRdata, e);
    endtask
    task op(input [3:0] c, input [7:0] b, input w, input [7:0] dst);
        @(posedge mclk) opValid <= 1'b1;
        opCode <= c;
        opOperand <= b;
        opToWork <= w;
        opDestAddr <= dst;
        @(posedge mclk) opValid <= 1'b0;
        #1;
    endtask
    task sys(input [2:0] s);
        @(posedge mclk) {sleepInstr, dogRefreshInstr, dogExpire} <= s;
        @(posedge mclk) {sleepInstr, dogRefreshInstr, dogExpire} <= 3'b000;
        #1;
    endtask
    task tbl(input [15:0] w, input [7:0] d);
        @(posedge mclk) tableRead <= 1'b1;
        tableWord <= w;
        tableDest <= d;
        @(posedge mclk) tableRead <= 1'b0;
        #1;
    endtask
    task endt(input [31:0] n);
        $display("test %0s done", n);
    endtask
    task final_report;
        $display("compared %0d, mismatches %0d", n_compared, n_errors);
        if (n_errors == 0 && n_compared > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask

    // A hung handshake must still reach the verdict.
    always @(posedge mclk) begin
        cyc = cyc + 1;
        if (cyc == 3000) begin
            n_errors = n_errors + 1;
            final_report;
        end
    end

    initial begin
        {mclk, rst_n, regWr, regRd, opValid, opToWork, fetchStep} = 7'h00;
        {sleepInstr, dogRefreshInstr, dogExpire, tableRead} = 4'h0;
        {regAddr, regWdata, opOperand, opDestAddr, tableDest} = 40'h0;
        opCode = `CSF_OP_NOP;
        tableWord = 16'h0000;
        ce = 1'b1;
        n_errors = 0;
        n_compared = 0;
        cyc = 0;
        repeat (3) @(posedge mclk);
        rst_n <= 1'b1;
        rd(`CSF_ADDR_STATUS, 8'h00);
        wr(`CSF_ADDR_STATUS, 8'hff);
        rd(`CSF_ADDR_STATUS, 8'h0f);
        rd(8'h20, 8'h00);
        endt("reg");
        op(`CSF_OP_MOVB, 8'h7f, 1'b1, 8'h00);
        chk(workReg, 8'h7f);
        op(`CSF_OP_ADD, 8'h01, 1'b1, 8'h00);
        chk({workReg, statusFlags}, 16'h800a);
        op(`CSF_OP_SUB, 8'h80, 1'b1, 8'h00);
        chk({workReg, statusFlags}, 16'h0007);
        op(`CSF_OP_RLC, 8'h00, 1'b1, 8'h00);
        chk({workReg, statusFlags}, 16'h0106);
        op(`CSF_OP_AND, 8'h01, 1'b1, 8'h00);
        chk({workReg, statusFlags}, 16'h0102);
        op(`CSF_OP_SUB, 8'h02, 1'b1, 8'h00);
        chk({workReg, statusFlags}, 16'hff00);
        op(`CSF_OP_ADD, 8'h81, 1'b1, 8'h00);
        chk({workReg, statusFlags}, 16'h8003);
        op(`CSF_OP_ADD, 8'h80, 1'b1, 8'h00);
        chk({workReg, statusFlags}, 16'h000d);
        op(`CSF_OP_ADC, 8'h0f, 1'b1, 8'h00);
        chk({workReg, statusFlags}, 16'h1002);
        op(`CSF_OP_RRC, 8'h03, 1'b1, 8'h00);
        chk({workReg, statusFlags}, 16'h0103);
        op(`CSF_OP_MOVA, 8'h00, 1'b0, 8'h40);
        chk({memWrEn, memWrAddr, memWrData}, {1'b1, 16'h4001});
        endt("alu");
        sys(3'b100);
        chk(statusFlags[5:4], 2'b01);
        sys(3'b001);
        chk(statusFlags[5:4], 2'b11);
        wr(`CSF_ADDR_STATUS, 8'h00);
        chk(statusFlags, 8'h30);
        sys(3'b100);
        chk(statusFlags[5:4], 2'b01);
        sys(3'b010);
        chk(statusFlags[5:4], 2'b00);
        sys(3'b011);
        chk(statusFlags[5:4], 2'b10);
        endt("sys");
        @(posedge mclk) fetchStep <= 1'b1;
        repeat (300) @(posedge mclk);
        fetchStep <= 1'b0;
        #1;
        chk(progCounter, 11'h12c);
        op(`CSF_OP_MOVB, 8'h3c, 1'b1, 8'h00);
        op(`CSF_OP_MOVA, 8'h00, 1'b0, `CSF_ADDR_PCL);
        d0 = dummyCycle;
        chk(progCounter, 11'h13c);
        @(posedge mclk) #1;
        chk({d0, dummyCycle}, 2'b10);
        endt("jump");
        wr(`CSF_ADDR_LPTR, 8'h12);
        rd(`CSF_ADDR_LPTR, 8'h12);
        chk(lookupPointer, 8'h12);
        op(`CSF_OP_INC, 8'h12, 1'b0, `CSF_ADDR_LPTR);
        chk(lookupPointer, 8'h13);
        wr(`CSF_ADDR_EVMASK, 8'h00);
        wr(`CSF_ADDR_EVSTAT, 8'h0f);
        tbl(16'ha55a, 8'h40);
        chk({memWrEn, memWrAddr, memWrData}, {1'b1, 16'h405a});
        chk(lookupHighByte, 8'ha5);
        rd(`CSF_ADDR_LHIGH, 8'ha5);
        rd(`CSF_ADDR_EVSTAT, 8'h02);
        chk(irq, 1'b0);
        wr(`CSF_ADDR_EVMASK, 8'h02);
        @(posedge mclk) #1;
        chk(irq, 1'b1);
        wr(`CSF_ADDR_EVSTAT, 8'h02);
        @(posedge mclk) #1;
        chk(irq, 1'b0);
        rd(`CSF_ADDR_EVSTAT, 8'h00);
        endt("evt");
        sys(3'b101);
        chk(statusFlags[5:4], 2'b11);
        @(posedge mclk) rst_n <= 1'b0;
        repeat (3) @(posedge mclk);
        rst_n <= 1'b1;
        #1;
        chk({irq, statusFlags}, 9'h000);
        rd(`CSF_ADDR_STATUS, 8'h00);
        endt("rst");
        final_report;
    end
endmodule // tb_top
